/* File: core/spcs_consts.svh */
`ifndef SPCS_CONSTS_SVH
`define SPCS_CONSTS_SVH

// register indices; byte address is four times the index
`define SPCS_IDX_MODE      16'hFF70
`define SPCS_IDX_RUN       16'hFF72
`define SPCS_IDX_ERR       16'hFF73
`define SPCS_IDX_DATA      16'hFF74
`define SPCS_IDX_IRQ_STAT  16'hFF76
`define SPCS_IDX_IRQ_MASK  16'hFF77

// mode/config field positions
`define SPCS_MODE_SER_EN   0
`define SPCS_MODE_SEL_LSB  1
`define SPCS_MODE_SEL_MSB  2
`define SPCS_MODE_PAR_EN   3

// run/enable field positions
`define SPCS_RUN_TX_ALLOW  0
`define SPCS_RUN_TX_KICK   1
`define SPCS_RUN_RX_ALLOW  2
`define SPCS_RUN_RX_KICK   3

// error flag field positions
`define SPCS_ERR_OVERRUN   0
`define SPCS_ERR_PARITY    1
`define SPCS_ERR_FRAME     2

// interrupt status/mask field positions
`define SPCS_IRQ_TX_DONE   0
`define SPCS_IRQ_RX_DONE   1
`define SPCS_IRQ_ERROR     2

// reset values
`define SPCS_MODE_RESET    4'h0
`define SPCS_RUN_RESET     4'h0
`define SPCS_ERR_RESET     3'h0
`define SPCS_IRQ_RESET     3'h0

// timing: system clock and bit rate
`define SPCS_CLK_HZ        20000000
`define SPCS_BAUD_BPS      2400

`endif

/* File: core/spcs_pkg.sv */
package spcs_pkg;

	// transmit sequencer states
	typedef enum logic [0:0]
	{
		SPCS_TX_IDLE  = 1'b0,
		SPCS_TX_SHIFT = 1'b1
	} spcs_tx_state_t;

	// receive sequencer states
	typedef enum logic [1:0]
	{
		SPCS_RX_IDLE  = 2'b00,
		SPCS_RX_ARMED = 2'b01,
		SPCS_RX_FRAME = 2'b10
	} spcs_rx_state_t;

endpackage

/* File: core/spcs_frame_engine.sv */
`timescale 1ns/1ps

module spcs_frame_engine (
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic [15:0] i_bit_cycles,
	input  wire logic        i_eight_bit,
	input  wire logic        i_parity_en,
	input  wire logic        i_tx_start,
	input  wire logic        i_tx_allow,
	input  wire logic [7:0]  i_tx_data,
	output logic             o_tx_busy,
	output logic             o_txd,
	output logic             o_tx_done,
	input  wire logic        i_rx_arm,
	input  wire logic        i_rx_allow,
	input  wire logic        i_rxd,
	output logic             o_rx_busy,
	output logic             o_rx_done,
	output logic [7:0]       o_rx_data,
	output logic             o_frame_err,
	output logic             o_parity_err
);

	spcs_pkg::spcs_tx_state_t tx_state_reg;
	spcs_pkg::spcs_rx_state_t rx_state_reg;
	logic [10:0] tx_shift_reg;
	logic [3:0]  tx_left_reg;
	logic [15:0] tx_cnt_reg;
	logic [10:0] rx_shift_reg;
	logic [3:0]  rx_idx_reg;
	logic [15:0] rx_cnt_reg;
	logic [10:0] tx_frame;
	logic [3:0]  frame_bits;
	logic [10:0] rx_vec;
	logic [7:0]  rx_word;
	logic        rx_par_bad;
	logic        rx_stop_bad;
	logic        tx_par;

	// frame length and outgoing frame: start, data, optional parity, stop
	always_comb
	begin
		frame_bits = 4'(4'd10 - {3'd0, ~i_eight_bit} + {3'd0, i_parity_en});
		tx_par = i_eight_bit ? ^i_tx_data : ^i_tx_data[6:0];
		if (i_eight_bit && i_parity_en)
			tx_frame = {1'b1, tx_par, i_tx_data, 1'b0};
		else if (i_eight_bit)
			tx_frame = {2'b11, i_tx_data, 1'b0};
		else if (i_parity_en)
			tx_frame = {2'b11, tx_par, i_tx_data[6:0], 1'b0};
		else
			tx_frame = {3'b111, i_tx_data[6:0], 1'b0};
	end

	// transmit sequencer, aborted when transmit is disallowed
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			tx_state_reg <= spcs_pkg::SPCS_TX_IDLE;
			tx_shift_reg <= 11'h7FF;
			tx_left_reg  <= 4'h0;
			tx_cnt_reg   <= 16'h0000;
			o_tx_done    <= 1'b0;
		end
		else
		begin
			o_tx_done <= 1'b0;
			case (tx_state_reg)
				spcs_pkg::SPCS_TX_IDLE:
				begin
					if (i_tx_start)
					begin
						tx_state_reg <= spcs_pkg::SPCS_TX_SHIFT;
						tx_shift_reg <= tx_frame;
						tx_left_reg  <= frame_bits;
						tx_cnt_reg   <= 16'(i_bit_cycles - 16'h0001);
					end
				end
				default:
				begin
					if (!i_tx_allow)
					begin
						tx_state_reg <= spcs_pkg::SPCS_TX_IDLE;
						tx_shift_reg <= 11'h7FF;
					end
					else if (tx_cnt_reg != 16'h0000)
						tx_cnt_reg <= 16'(tx_cnt_reg - 16'h0001);
					else
					begin
						tx_cnt_reg   <= 16'(i_bit_cycles - 16'h0001);
						tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
						tx_left_reg  <= 4'(tx_left_reg - 4'h1);
						if (tx_left_reg == 4'h1)
						begin
							tx_state_reg <= spcs_pkg::SPCS_TX_IDLE;
							o_tx_done    <= 1'b1;
						end
					end
				end
			endcase
		end
	end

	assign o_tx_busy = (tx_state_reg == spcs_pkg::SPCS_TX_SHIFT);
	assign o_txd     = tx_shift_reg[0];

	// received vector aligned so the start bit sits in bit 0
	always_comb
	begin
		rx_vec      = {i_rxd, rx_shift_reg[10:1]} >> (4'd11 - frame_bits);
		rx_word     = i_eight_bit ? rx_vec[8:1] : {1'b0, rx_vec[7:1]};
		rx_par_bad  = i_parity_en && ((^rx_word) != rx_vec[i_eight_bit ? 9 : 8]);
		rx_stop_bad = !rx_vec[frame_bits - 4'h1];
	end

	// receive sequencer: armed by a kick, samples mid-bit
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rx_state_reg <= spcs_pkg::SPCS_RX_IDLE;
			rx_shift_reg <= 11'h000;
			rx_idx_reg   <= 4'h0;
			rx_cnt_reg   <= 16'h0000;
			o_rx_done    <= 1'b0;
			o_rx_data    <= 8'h00;
			o_frame_err  <= 1'b0;
			o_parity_err <= 1'b0;
		end
		else
		begin
			o_rx_done    <= 1'b0;
			o_frame_err  <= 1'b0;
			o_parity_err <= 1'b0;
			if (!i_rx_allow)
				rx_state_reg <= spcs_pkg::SPCS_RX_IDLE;
			else
			begin
				case (rx_state_reg)
					spcs_pkg::SPCS_RX_IDLE:
						if (i_rx_arm)
							rx_state_reg <= spcs_pkg::SPCS_RX_ARMED;
					spcs_pkg::SPCS_RX_ARMED:
						if (!i_rxd)
						begin
							rx_state_reg <= spcs_pkg::SPCS_RX_FRAME;
							rx_cnt_reg   <= {1'b0, i_bit_cycles[15:1]};
							rx_idx_reg   <= 4'h0;
						end
					default:
					begin
						if (rx_cnt_reg != 16'h0000)
							rx_cnt_reg <= 16'(rx_cnt_reg - 16'h0001);
						else if (rx_idx_reg == 4'h0 && i_rxd)
							rx_state_reg <= spcs_pkg::SPCS_RX_ARMED; // false start
						else
						begin
							rx_cnt_reg   <= 16'(i_bit_cycles - 16'h0001);
							rx_shift_reg <= {i_rxd, rx_shift_reg[10:1]};
							rx_idx_reg   <= 4'(rx_idx_reg + 4'h1);
							if (rx_idx_reg == 4'(frame_bits - 4'h1))
							begin
								rx_state_reg <= spcs_pkg::SPCS_RX_IDLE;
								o_rx_done    <= 1'b1;
								o_rx_data    <= rx_word;
								o_frame_err  <= rx_stop_bad;
								o_parity_err <= rx_par_bad;
							end
						end
					end
				endcase
			end
		end
	end

	assign o_rx_busy = (rx_state_reg != spcs_pkg::SPCS_RX_IDLE);

endmodule

/* File: core/spcs_serial_ctrl.sv */
`timescale 1ns/1ps
`include "spcs_consts.svh"

// Behaviour
// - serial enable hands port pins from general-purpose use to the serial interface
// - parity enable turns transmit parity generation and receive checking on or off
// - receive run bit reads receiver activity; writing it starts a receive
// - receive enable, reset to 0, gates reception
// - transmit run bit reads 1 while sending, reset 0; writing it starts sending
// - framing error flag set on bad stop bit; readable, cleared by writing a one
// - parity error flag, reset 0, set on parity mismatch; writing a one clears it
// - overrun error flag, reset 0, set when new data overwrites unread data
module spcs_serial_ctrl #(
	parameter logic [15:0] BIT_CYCLES = 16'(`SPCS_CLK_HZ / `SPCS_BAUD_BPS)
) (
	input  wire logic        i_clk,
	input  wire logic        i_arst_n,
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [17:0] i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic [31:0]      o_wb_dat,
	output logic             o_wb_ack,
	input  wire logic [1:0]  i_shared_port_pins_in,
	output logic [1:0]       o_shared_port_pins_out,
	output logic [1:0]       o_shared_port_pins_oe,
	input  wire logic [1:0]  i_gp_out,
	input  wire logic [1:0]  i_gp_oe,
	output logic [1:0]       o_gp_in,
	output logic             o_irq
);

	logic        rst_meta_reg;
	logic        rst_n_reg;
	logic [1:0]  pin_meta_reg;
	logic [1:0]  pin_sync_reg;
	logic [3:0]  mode_reg;
	logic        tx_allow_reg;
	logic        rx_allow_reg;
	logic        frame_err_flag_reg;
	logic        parity_err_flag_reg;
	logic        overrun_err_flag_reg;
	logic [7:0]  tx_data_reg;
	logic        rx_full_reg;
	logic [2:0]  irq_stat_reg;
	logic [2:0]  irq_mask_reg;
	logic [31:0] rd_data_reg;
	logic        ack_reg;
	logic        req;
	logic        wr;
	logic        rd;
	logic [15:0] idx;
	logic [3:0]  wdat;
	logic        async_mode;
	logic        ser_en;
	logic        tx_start;
	logic        rx_arm;
	logic        tx_busy;
	logic        txd;
	logic        tx_done;
	logic        rx_busy;
	logic        rx_done;
	logic [7:0]  rx_data;
	logic        frame_err_ev;
	logic        parity_err_ev;
	logic        overrun_ev;
	logic [2:0]  irq_ev;
	logic        hit_mode;
	logic        hit_run;
	logic        hit_err;
	logic        hit_data;
	logic        hit_stat;
	logic        hit_mask;
	logic [2:0]  err_clr;

	// reset release through two flip-flops
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			rst_meta_reg <= 1'b0;
			rst_n_reg    <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_n_reg    <= rst_meta_reg;
		end
	end

	// pin inputs synchronised before use
	always_ff @(posedge i_clk or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			pin_meta_reg <= 2'h3;
			pin_sync_reg <= 2'h3;
		end
		else
		begin
			pin_meta_reg <= i_shared_port_pins_in;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	// bus request decode
	assign req  = i_wb_cyc && i_wb_stb && !ack_reg;
	assign wr   = req && i_wb_we && i_wb_sel[0];
	assign rd   = req && !i_wb_we;
	assign idx  = i_wb_adr[17:2];
	assign wdat = i_wb_dat[3:0];

	// register select, one hit per mapped index
	always_comb
	begin
		hit_mode = 1'b0;
		hit_run  = 1'b0;
		hit_err  = 1'b0;
		hit_data = 1'b0;
		hit_stat = 1'b0;
		hit_mask = 1'b0;
		if (idx == `SPCS_IDX_MODE)
			hit_mode = 1'b1;
		else if (idx == `SPCS_IDX_RUN)
			hit_run = 1'b1;
		else if (idx == `SPCS_IDX_ERR)
			hit_err = 1'b1;
		else if (idx == `SPCS_IDX_DATA)
			hit_data = 1'b1;
		else if (idx == `SPCS_IDX_IRQ_STAT)
			hit_stat = 1'b1;
		else if (idx == `SPCS_IDX_IRQ_MASK)
			hit_mask = 1'b1;
	end

	// mode fields
	assign ser_en     = mode_reg[`SPCS_MODE_SER_EN];
	assign async_mode = mode_reg[`SPCS_MODE_SEL_MSB];

	// mode and configuration register
	always_ff @(posedge i_clk or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			mode_reg <= `SPCS_MODE_RESET;
		else if (wr && hit_mode)
			mode_reg <= wdat;
	end

	// receive and transmit enables
	always_ff @(posedge i_clk or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			tx_allow_reg <= 1'b0;
			rx_allow_reg <= 1'b0;
		end
		else if (wr && hit_run)
		begin
			tx_allow_reg <= wdat[`SPCS_RUN_TX_ALLOW];
			rx_allow_reg <= wdat[`SPCS_RUN_RX_ALLOW];
		end
	end

	// transmit kick: a one written to the run bit with allow set starts sending
	assign tx_start = wr && hit_run && wdat[`SPCS_RUN_TX_KICK]
		&& wdat[`SPCS_RUN_TX_ALLOW] && ser_en && async_mode && !tx_busy;

	// receive kick: arms only when the same write allows reception
	assign rx_arm = wr && hit_run && wdat[`SPCS_RUN_RX_KICK]
		&& wdat[`SPCS_RUN_RX_ALLOW]
		&& ser_en && async_mode;

	// transmit data latch
	always_ff @(posedge i_clk or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			tx_data_reg <= 8'h00;
		else if (wr && hit_data && !tx_busy)
			tx_data_reg <= i_wb_dat[7:0];
	end

	// frame engine
	spcs_frame_engine u_engine (
		.i_clk        (i_clk),
		.i_rst_n      (rst_n_reg),
		.i_bit_cycles (BIT_CYCLES),
		.i_eight_bit  (mode_reg[`SPCS_MODE_SEL_LSB]),
		.i_parity_en  (mode_reg[`SPCS_MODE_PAR_EN]),
		.i_tx_start   (tx_start),
		.i_tx_allow   (tx_allow_reg && ser_en),
		.i_tx_data    (tx_data_reg),
		.o_tx_busy    (tx_busy),
		.o_txd        (txd),
		.o_tx_done    (tx_done),
		.i_rx_arm     (rx_arm),
		.i_rx_allow   ((rx_allow_reg || rx_arm) && ser_en),
		.i_rxd        (pin_sync_reg[0]),
		.o_rx_busy    (rx_busy),
		.o_rx_done    (rx_done),
		.o_rx_data    (rx_data),
		.o_frame_err  (frame_err_ev),
		.o_parity_err (parity_err_ev)
	);

	// unread received data tracking; arrival wins over a read
	always_ff @(posedge i_clk or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			rx_full_reg <= 1'b0;
		else if (rx_done)
			rx_full_reg <= 1'b1;
		else if (rd && hit_data)
			rx_full_reg <= 1'b0;
	end

	assign overrun_ev = rx_done && rx_full_reg;

	// written ones clear error flags, zeros leave them
	assign err_clr = (wr && hit_err) ? wdat[2:0] : 3'h0;

	// framing error flag, set wins over a clear
	always_ff @(posedge i_clk or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			frame_err_flag_reg <= 1'b0;
		else if (frame_err_ev)
			frame_err_flag_reg <= 1'b1;
		else if (err_clr[`SPCS_ERR_FRAME])
			frame_err_flag_reg <= 1'b0;
	end

	// parity error flag, set wins over a clear
	always_ff @(posedge i_clk or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			parity_err_flag_reg <= 1'b0;
		else if (parity_err_ev)
			parity_err_flag_reg <= 1'b1;
		else if (err_clr[`SPCS_ERR_PARITY])
			parity_err_flag_reg <= 1'b0;
	end

	// overrun error flag, set wins over a clear
	always_ff @(posedge i_clk or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			overrun_err_flag_reg <= 1'b0;
		else if (overrun_ev)
			overrun_err_flag_reg <= 1'b1;
		else if (err_clr[`SPCS_ERR_OVERRUN])
			overrun_err_flag_reg <= 1'b0;
	end

	// interrupt events
	always_comb
	begin
		irq_ev = 3'h0;
		irq_ev[`SPCS_IRQ_TX_DONE] = tx_done;
		irq_ev[`SPCS_IRQ_RX_DONE] = rx_done;
		irq_ev[`SPCS_IRQ_ERROR]   = frame_err_ev || parity_err_ev || overrun_ev;
	end

	// sticky interrupt status, write one to clear, set wins
	always_ff @(posedge i_clk or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			irq_stat_reg <= `SPCS_IRQ_RESET;
		else if (wr && hit_stat)
			irq_stat_reg <= (irq_stat_reg & ~i_wb_dat[2:0]) | irq_ev;
		else
			irq_stat_reg <= irq_stat_reg | irq_ev;
	end

	// interrupt mask
	always_ff @(posedge i_clk or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			irq_mask_reg <= `SPCS_IRQ_RESET;
		else if (wr && hit_mask)
			irq_mask_reg <= i_wb_dat[2:0];
	end

	// level interrupt
	always_ff @(posedge i_clk or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			o_irq <= 1'b0;
		else
			o_irq <= |(irq_stat_reg & irq_mask_reg);
	end

	// read data and acknowledge, one cycle after the request
	always_ff @(posedge i_clk or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			ack_reg     <= 1'b0;
			rd_data_reg <= 32'h0000_0000;
		end
		else
		begin
			ack_reg     <= req;
			rd_data_reg <= 32'h0000_0000;
			if (rd)
			begin
				if (idx == `SPCS_IDX_MODE)
					rd_data_reg[3:0] <= mode_reg;
				else if (idx == `SPCS_IDX_RUN)
					rd_data_reg[3:0] <= {rx_busy, rx_allow_reg, tx_busy, tx_allow_reg};
				else if (idx == `SPCS_IDX_ERR)
					rd_data_reg[2:0] <= {frame_err_flag_reg, parity_err_flag_reg,
						overrun_err_flag_reg};
				else if (idx == `SPCS_IDX_DATA)
					rd_data_reg[7:0] <= rx_data;
				else if (idx == `SPCS_IDX_IRQ_STAT)
					rd_data_reg[2:0] <= irq_stat_reg;
				else if (idx == `SPCS_IDX_IRQ_MASK)
					rd_data_reg[2:0] <= irq_mask_reg;
			end
		end
	end

	assign o_wb_ack = ack_reg;
	assign o_wb_dat = rd_data_reg;

	// pin function selection: pin 0 receive, pin 1 transmit
	always_comb
	begin
		if (ser_en)
		begin
			o_shared_port_pins_out = {txd, 1'b0};
			o_shared_port_pins_oe  = 2'b10;
		end
		else
		begin
			o_shared_port_pins_out = i_gp_out;
			o_shared_port_pins_oe  = i_gp_oe;
		end
	end

	assign o_gp_in = pin_sync_reg;

endmodule

/* File: sim/spcs_serial_ctrl_assertions.sv */
`timescale 1ns/1ps
`include "spcs_consts.svh"

module spcs_ctrl_chk (
	input wire logic        i_clk,
	input wire logic        i_arst_n,
	input wire logic        i_wb_cyc,
	input wire logic        i_wb_stb,
	input wire logic        i_wb_we,
	input wire logic [17:0] i_wb_adr,
	input wire logic [3:0]  i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	input wire logic [31:0] o_wb_dat,
	input wire logic        o_wb_ack,
	input wire logic [1:0]  o_shared_port_pins_out,
	input wire logic [1:0]  o_shared_port_pins_oe,
	input wire logic [1:0]  i_gp_out,
	input wire logic [1:0]  i_gp_oe,
	input wire logic        o_irq
);
	logic       take;
	logic       wr_en;
	logic       run_wr;
	logic [3:0] mode_reg;
	logic [2:0] mask_reg;

	// request taken at this edge and its write qualifiers
	assign take = i_wb_cyc && i_wb_stb && !o_wb_ack;
	assign wr_en = take && i_wb_we && i_wb_sel[0];
	assign run_wr = wr_en && i_wb_adr[17:2] == `SPCS_IDX_RUN;

	// shadow copies of mode and interrupt mask
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			mode_reg <= 4'h0;
			mask_reg <= 3'h0;
		end
		else if (wr_en && i_wb_adr[17:2] == `SPCS_IDX_MODE)
			mode_reg <= i_wb_dat[3:0];
		else if (wr_en && i_wb_adr[17:2] == `SPCS_IDX_IRQ_MASK)
			mask_reg <= i_wb_dat[2:0];
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_arst_n);

	ack_latency_a: assert property (take |=> o_wb_ack)
		else $error("bus request not answered next cycle");
	ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("bus ack held too long");
	dat_idle_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
		else $error("read data outside answer cycle");
	pins_serial_a: assert property (mode_reg[0] |-> o_shared_port_pins_oe == 2'h2
		&& !o_shared_port_pins_out[0]) else $error("pins not handed to serial");
	pins_gp_a: assert property (!mode_reg[0] |-> o_shared_port_pins_oe == i_gp_oe
		&& o_shared_port_pins_out == i_gp_out) else $error("pins not general purpose");
	tx_start_a: assert property (run_wr && i_wb_dat[1:0] == 2'h3
		&& mode_reg[2] && mode_reg[0] |-> ##[1:4] !o_shared_port_pins_out[1])
		else $error("no start bit after kick");
	tx_gated_a: assert property (run_wr && !i_wb_dat[0] && mode_reg[0]
		|-> ##3 o_shared_port_pins_out[1] [*8]) else $error("line busy without allow");
	irq_masked_a: assert property (mask_reg == 3'h0 |=> !o_irq)
		else $error("irq with all sources masked");
endmodule

/* File: sim/spcs_peer_model.sv */
`timescale 1ns/1ps

module spcs_peer_model #(
	parameter int BC = 8
) (
	input  wire logic i_clk,
	input  wire logic i_line,
	output logic      o_line
);
	// idle level of the asynchronous line
	initial o_line = 1'b1;

	// one bit period on the line
	task automatic put(input logic b);
		o_line <= b;
		repeat (BC) @(posedge i_clk);
	endtask

	// frame out: start, data lsb first, parity, stop, idle bit
	task automatic send(input logic [7:0] d, input logic pe, input logic bp, input logic st);
		@(posedge i_clk);
		put(1'b0);
		for (int i = 0; i < 8; i++)
			put(d[i]);
		if (pe)
			put(^d ^ bp);
		put(st);
		put(1'b1);
	endtask

	// frame in, sampled mid-bit; ok low when no start bit came
	task automatic recv(input logic pe, output logic [7:0] d, output logic p,
		output logic s, output logic ok);
		int n;
		n = 0;
		while (i_line !== 1'b0 && n < 100)
		begin
			@(posedge i_clk);
			n++;
		end
		ok = !i_line;
		repeat (BC / 2) @(posedge i_clk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BC) @(posedge i_clk);
			d[i] = i_line;
		end
		p = 1'b0;
		if (pe)
		begin
			repeat (BC) @(posedge i_clk);
			p = i_line;
		end
		repeat (BC) @(posedge i_clk);
		s = i_line;
	endtask
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/1ps

module tb_top;
	logic        clk;
	logic        arst_n;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [17:0] adr;
	logic [31:0] wdat;
	logic [31:0] dat_o;
	logic [31:0] rdat;
	logic        ack;
	logic        irq;
	logic [1:0]  pin_out;
	logic [1:0]  pin_oe;
	logic [1:0]  gp_out;
	logic [1:0]  gp_oe;
	logic [1:0]  gp_in;
	logic [1:0]  pins;
	logic        peer_line;
	logic [7:0]  rx_d;
	logic        rx_p;
	logic        rx_s;
	logic        rx_ok;
	int          mismatches;
	int          total_checks;
	logic [15:0] ridx [6] = '{16'hFF70, 16'hFF71, 16'hFF72, 16'hFF73, 16'hFF76, 16'hFF77};

	// wire levels: pin1 pulled up, pin0 driven by the peer when released
	assign pins = {pin_oe[1] ? pin_out[1] : 1'b1, pin_oe[0] ? pin_out[0] : peer_line};

	always #25 clk = ~clk;

	spcs_serial_ctrl #(.BIT_CYCLES(16'h0008)) dut (.i_clk(clk), .i_arst_n(arst_n),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF),
		.i_wb_dat(wdat), .o_wb_dat(dat_o), .o_wb_ack(ack), .i_shared_port_pins_in(pins),
		.o_shared_port_pins_out(pin_out), .o_shared_port_pins_oe(pin_oe),
		.i_gp_out(gp_out), .i_gp_oe(gp_oe), .o_gp_in(gp_in), .o_irq(irq));

	spcs_peer_model #(.BC(8)) peer (.i_clk(clk), .i_line(pins[1]), .o_line(peer_line));

	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one classic bus cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [15:0] idx, input logic [31:0] d);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'h0};
		wdat <= d;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1)
		begin
			mismatches++;
			finish_test();
		end
	endtask

	task automatic wr(input logic [15:0] idx, input logic [31:0] d);
		wb(1'b1, idx, d);
	endtask

	task automatic rd(input logic [15:0] idx, input logic [31:0] e);
		wb(1'b0, idx, 32'h0);
		chk(rdat, e);
	endtask

	task automatic tend(input string s);
		$display("test %s finished", s);
	endtask

	// faulty frame, then flag kept by a zero write and cleared by a one
	task automatic rx_err(input logic bp, input logic st, input logic [31:0] e);
		wr(16'hFF72, 32'hC);
		peer.send(8'h55, 1'b1, bp, st);
		rd(16'hFF73, e);
		wb(1'b0, 16'hFF74, 32'h0);
		wr(16'hFF73, 32'h0);
		rd(16'hFF73, e);
		wr(16'hFF73, e);
		rd(16'hFF73, 32'h0);
	endtask

	// main sequence
	initial
	begin
		clk = 1'b0;
		arst_n = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 18'h0;
		wdat = 32'h0;
		gp_out = 2'h0;
		gp_oe = 2'h1;
		mismatches = 0;
		total_checks = 0;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		wr(16'hFF71, 32'hF);
		foreach (ridx[i])
			rd(ridx[i], 32'h0);
		chk(32'({pin_oe, pin_out}), 32'({gp_oe, gp_out}));
		chk(32'(gp_in), 32'h2);
		tend("reset");
		wr(16'hFF70, 32'h7);
		chk(32'(pin_oe), 32'h2);
		wr(16'hFF74, 32'hA5);
		wr(16'hFF72, 32'h3);
		fork
			peer.recv(1'b0, rx_d, rx_p, rx_s, rx_ok);
			rd(16'hFF72, 32'h3);
		join
		chk(32'({rx_ok, rx_s, rx_d}), 32'h3A5);
		repeat (8) @(posedge clk);
		rd(16'hFF72, 32'h1);
		rd(16'hFF76, 32'h1);
		chk(32'(irq), 32'h0);
		wr(16'hFF76, 32'h1);
		wr(16'hFF72, 32'h2);
		rd(16'hFF72, 32'h0);
		tend("transmit");
		wr(16'hFF70, 32'hF);
		wr(16'hFF74, 32'h07);
		wr(16'hFF72, 32'h3);
		peer.recv(1'b1, rx_d, rx_p, rx_s, rx_ok);
		chk(32'({rx_ok, rx_s, rx_p, rx_d}), 32'h707);
		repeat (8) @(posedge clk);
		wr(16'hFF76, 32'h1);
		tend("parity transmit");
		wr(16'hFF77, 32'h2);
		wr(16'hFF72, 32'hC);
		fork
			peer.send(8'h3C, 1'b1, 1'b0, 1'b1);
			rd(16'hFF72, 32'hC);
		join
		rd(16'hFF73, 32'h0);
		rd(16'hFF74, 32'h3C);
		chk(32'(irq), 32'h1);
		wr(16'hFF76, 32'h2);
		@(posedge clk);
		chk(32'(irq), 32'h0);
		rd(16'hFF72, 32'h4);
		tend("receive");
		rx_err(1'b1, 1'b1, 32'h2);
		rx_err(1'b0, 1'b0, 32'h4);
		tend("errors");
		for (int i = 0; i < 2; i++)
		begin
			wr(16'hFF72, 32'hC);
			peer.send(8'h11, 1'b1, 1'b0, 1'b1);
		end
		rd(16'hFF73, 32'h1);
		wr(16'hFF73, 32'h1);
		rd(16'hFF73, 32'h0);
		tend("overrun");
		wr(16'hFF76, 32'h7);
		wr(16'hFF72, 32'h8);
		peer.send(8'h33, 1'b1, 1'b0, 1'b1);
		rd(16'hFF72, 32'h0);
		rd(16'hFF76, 32'h0);
		tend("receive gated");
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(16'hFF70, 32'h0);
		tend("second reset");
		finish_test();
	end
endmodule

bind spcs_serial_ctrl spcs_ctrl_chk u_chk (.i_clk, .i_arst_n, .i_wb_cyc, .i_wb_stb,
	.i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack,
	.o_shared_port_pins_out, .o_shared_port_pins_oe, .i_gp_out, .i_gp_oe, .o_irq);
